// >>> verilog/psl_defines.vh
`ifndef PSL_DEFINES_VH
`define PSL_DEFINES_VH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define PSL_ADDR_W          16
`define PSL_CTRL_OFFSET     16'h40c0
`define PSL_STAT_OFFSET     16'h40c4
`define PSL_CTRL_RESET      16'h0311

// ----------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------
`define PSL_FORCE_EN        15
`define PSL_FORCE_HI        14
`define PSL_FORCE_LO        13
`define PSL_ACT_UNCOND      12
`define PSL_FDX_ON          11
`define PSL_HDX_ON          10
`define PSL_TX_BLK          9
`define PSL_RX_BLK          8
`define PSL_TX_ON           7
`define PSL_RX_ON           6
`define PSL_FAST_ON         5
`define PSL_SLOW_ON         4
`define PSL_COL_BLK         3
`define PSL_FAST_BLK        2
`define PSL_SLOW_BLK        1
`define PSL_CHECK_LVL       0

// ----------------------------------------------------------------
// Force pattern codes
// ----------------------------------------------------------------
`define PSL_FORCE_BLINK2    2'h3
`define PSL_FORCE_BLINK1    2'h2
`define PSL_FORCE_ON        2'h1
`define PSL_FORCE_OFF       2'h0

// ----------------------------------------------------------------
// AXI responses
// ----------------------------------------------------------------
`define PSL_RESP_OKAY       2'h0
`define PSL_RESP_SLVERR     2'h2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PSL_CLK_KHZ         25000
`define PSL_HOLD_MS         10
`define PSL_BLINK1_MS       250
`define PSL_BLINK2_MS       60
`define PSL_HOLD_CYC        (`PSL_HOLD_MS * `PSL_CLK_KHZ)
`define PSL_BLINK1_CYC      (`PSL_BLINK1_MS * `PSL_CLK_KHZ)
`define PSL_BLINK2_CYC      (`PSL_BLINK2_MS * `PSL_CLK_KHZ)
`define PSL_CNT_W           24

`endif

// >>> verilog/psl_blink_gen.v
`timescale 1ns/1ps
`default_nettype none

`include "psl_defines.vh"

// ----------------------------------------------------------------
// Square wave: phase toggles every HALF_CYCLES clocks
// ----------------------------------------------------------------
module psl_blink_gen #(
  parameter [`PSL_CNT_W-1:0] HALF_CYCLES = 24'h000010
) (
  input  wire mclk,
  input  wire rst,
  output reg  phase
);

  reg [`PSL_CNT_W-1:0] count_r;

  always @(posedge mclk) begin
    if (rst) begin
      count_r <= {`PSL_CNT_W{1'b0}};
      phase   <= 1'b0;
    end else if (count_r == HALF_CYCLES - 24'h000001) begin
      count_r <= {`PSL_CNT_W{1'b0}};
      phase   <= ~phase;
    end else begin
      count_r <= count_r + 24'h000001;
    end
  end

endmodule

`default_nettype wire

// >>> verilog/psl_status_led.v
// What this block does
// - Force enable drives LED from pattern only
// - Pattern 11 blinks mode2, 10 blinks mode1
// - Unconditional bit lets gated activity blink even if the LED was dark before
// - Full duplex link turns LED on
// - Half duplex link turns LED on
// - Transmit activity blinks at mode2 when gated
// - Receive activity blinks at mode2 when gated
// - Transmit activity holds LED on 10ms
// - Receive activity holds LED on 10ms
// - 100Mbps link turns LED on
// - 10Mbps link turns LED on
// - Collision on up link blinks LED
// - 100Mbps link blinks LED
// - 10Mbps link blinks LED
// - Link check state shows chosen level
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

`include "psl_defines.vh"

module psl_status_led #(
  parameter [`PSL_CNT_W-1:0] HOLD_CYCLES = `PSL_HOLD_CYC,
  parameter [`PSL_CNT_W-1:0] BLINK1_HALF = `PSL_BLINK1_CYC,
  parameter [`PSL_CNT_W-1:0] BLINK2_HALF = `PSL_BLINK2_CYC
) (
  input  wire                   mclk,
  input  wire                   rst,
  // Status from the PHY core
  input  wire                   linkUp,
  input  wire                   speedFast,
  input  wire                   fullDuplex,
  input  wire                   txActive,
  input  wire                   rxActive,
  input  wire                   collision,
  input  wire                   phyActive,
  input  wire                   anLinkCheck,
  // LED drive, high = lit
  output reg                    ledOn,
  // AXI4-Lite slave
  input  wire [`PSL_ADDR_W-1:0] s_axi_awaddr,
  input  wire                   s_axi_awvalid,
  output reg                    s_axi_awready,
  input  wire [31:0]            s_axi_wdata,
  input  wire [3:0]             s_axi_wstrb,
  input  wire                   s_axi_wvalid,
  output reg                    s_axi_wready,
  output reg  [1:0]             s_axi_bresp,
  output reg                    s_axi_bvalid,
  input  wire                   s_axi_bready,
  input  wire [`PSL_ADDR_W-1:0] s_axi_araddr,
  input  wire                   s_axi_arvalid,
  output reg                    s_axi_arready,
  output reg  [31:0]            s_axi_rdata,
  output reg  [1:0]             s_axi_rresp,
  output reg                    s_axi_rvalid,
  input  wire                   s_axi_rready
);

  // ----------------------------------------------------------------
  // Mode selection states
  // ----------------------------------------------------------------
  localparam [3:0] ST_STEADY = 4'h1;
  localparam [3:0] ST_BLINK  = 4'h2;
  localparam [3:0] ST_CHECK  = 4'h4;
  localparam [3:0] ST_FORCE  = 4'h8;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg  [15:0]            ctrl_r;
  reg  [`PSL_ADDR_W-1:0] awAddr_r;
  reg                    awHave_r;
  reg  [31:0]            wData_r;
  reg  [3:0]             wStrb_r;
  reg                    wHave_r;
  reg  [`PSL_CNT_W-1:0]  hold_r;
  reg                    steadyPrev_r;
  reg  [3:0]             state_r;
  reg  [3:0]             state_nxt;
  reg                    led_nxt;
  wire [1:0]             blinkPhase;
  wire                   holdLoad;
  wire                   holdActive;
  wire                   onAny;
  wire                   actGate;
  wire                   actBlink;
  wire                   otherBlink;
  wire                   blinkAny;
  wire                   writeFire;
  wire [15:0]            statusWord;

  // ----------------------------------------------------------------
  // Decoding shared by the read and write paths
  // ----------------------------------------------------------------
  function isCtrl;
    input [`PSL_ADDR_W-1:0] addr;
    begin
      isCtrl = ({2'b00, addr[`PSL_ADDR_W-1:2]} == (`PSL_CTRL_OFFSET >> 2));
    end
  endfunction

  function isStat;
    input [`PSL_ADDR_W-1:0] addr;
    begin
      isStat = ({2'b00, addr[`PSL_ADDR_W-1:2]} == (`PSL_STAT_OFFSET >> 2));
    end
  endfunction

  // ----------------------------------------------------------------
  // Blink sources: index 0 is mode1, index 1 is mode2
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : gBlink
      psl_blink_gen #(
        .HALF_CYCLES (g == 0 ? BLINK1_HALF : BLINK2_HALF)
      ) uBlink (
        .mclk  (mclk),
        .rst   (rst),
        .phase (blinkPhase[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Activity hold timer
  // ----------------------------------------------------------------
  // Reloaded while activity persists, so the LED stays lit at least
  // the hold time after the last activity seen on an up link.
  assign holdLoad = linkUp &
                    ((ctrl_r[`PSL_TX_ON] & txActive) |
                     (ctrl_r[`PSL_RX_ON] & rxActive));

  always @(posedge mclk) begin
    if (rst) begin
      hold_r <= {`PSL_CNT_W{1'b0}};
    end else if (holdLoad) begin
      hold_r <= HOLD_CYCLES;
    end else if (hold_r != {`PSL_CNT_W{1'b0}}) begin
      hold_r <= hold_r - 24'h000001;
    end
  end

  assign holdActive = (hold_r != {`PSL_CNT_W{1'b0}}) | holdLoad;

  // ----------------------------------------------------------------
  // Steady on-conditions
  // ----------------------------------------------------------------
  assign onAny = linkUp &
                 ((ctrl_r[`PSL_FDX_ON] & fullDuplex) |
                  (ctrl_r[`PSL_HDX_ON] & ~fullDuplex) |
                  (ctrl_r[`PSL_FAST_ON] & speedFast) |
                  (ctrl_r[`PSL_SLOW_ON] & ~speedFast)) |
                 holdActive;

  // ----------------------------------------------------------------
  // Blink conditions
  // ----------------------------------------------------------------
  // Activity blinking needs either the pattern bit or a steady
  // on-condition; without the unconditional bit it also needs the
  // LED to have been lit before the traffic started.
  assign actGate  = ctrl_r[`PSL_FORCE_LO] | onAny;
  assign actBlink = linkUp & actGate &
                    ((ctrl_r[`PSL_TX_BLK] & txActive) |
                     (ctrl_r[`PSL_RX_BLK] & rxActive)) &
                    (ctrl_r[`PSL_ACT_UNCOND] | steadyPrev_r);

  assign otherBlink = linkUp &
                      ((ctrl_r[`PSL_COL_BLK] & collision) |
                       (ctrl_r[`PSL_FAST_BLK] & speedFast) |
                       (ctrl_r[`PSL_SLOW_BLK] & ~speedFast));

  assign blinkAny = actBlink | otherBlink;

  // ----------------------------------------------------------------
  // Mode selection and LED level
  // ----------------------------------------------------------------
  always @* begin
    if (ctrl_r[`PSL_FORCE_EN]) begin
      state_nxt = ST_FORCE;
    end else if (phyActive & anLinkCheck) begin
      state_nxt = ST_CHECK;
    end else if (blinkAny) begin
      state_nxt = ST_BLINK;
    end else begin
      state_nxt = ST_STEADY;
    end
  end

  always @* begin
    case (state_nxt)
      ST_FORCE: begin
        case (ctrl_r[`PSL_FORCE_HI:`PSL_FORCE_LO])
          `PSL_FORCE_BLINK2: begin
            led_nxt = blinkPhase[1];
          end
          `PSL_FORCE_BLINK1: begin
            led_nxt = blinkPhase[0];
          end
          `PSL_FORCE_ON: begin
            led_nxt = 1'b1;
          end
          default: begin
            led_nxt = 1'b0;
          end
        endcase
      end
      ST_CHECK: begin
        led_nxt = ctrl_r[`PSL_CHECK_LVL];
      end
      ST_BLINK: begin
        // Activity uses the faster mode2; the other sources use mode1
        led_nxt = actBlink ? blinkPhase[1] : blinkPhase[0];
      end
      ST_STEADY: begin
        led_nxt = onAny;
      end
      default: begin
        led_nxt = 1'b0;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (rst) begin
      state_r      <= ST_STEADY;
      ledOn        <= 1'b0;
      steadyPrev_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ledOn   <= led_nxt;
      // The steady level is frozen while blinking so the activity
      // gate keeps seeing the level from before the traffic.
      if (state_nxt == ST_STEADY) begin
        steadyPrev_r <= onAny;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------
  assign statusWord = {7'h00, linkUp, state_r, onAny, blinkAny,
                       holdActive, ledOn};

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  // Address and data are captured independently in either order;
  // the register is written one cycle after both are held.
  assign writeFire = awHave_r & wHave_r & ~s_axi_bvalid;

  always @(posedge mclk) begin
    if (rst) begin
      awAddr_r      <= {`PSL_ADDR_W{1'b0}};
      awHave_r      <= 1'b0;
      wData_r       <= 32'h00000000;
      wStrb_r       <= 4'h0;
      wHave_r       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PSL_RESP_OKAY;
      ctrl_r        <= `PSL_CTRL_RESET;
    end else begin
      s_axi_awready <= ~awHave_r & ~s_axi_bvalid &
                       ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready  <= ~wHave_r & ~s_axi_bvalid &
                       ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid & s_axi_awready) begin
        awAddr_r <= s_axi_awaddr;
        awHave_r <= 1'b1;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
        wHave_r <= 1'b1;
      end
      if (writeFire) begin
        awHave_r     <= 1'b0;
        wHave_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (isCtrl(awAddr_r)) begin
          s_axi_bresp <= `PSL_RESP_OKAY;
          if (wStrb_r[0]) begin
            ctrl_r[7:0] <= wData_r[7:0];
          end
          if (wStrb_r[1]) begin
            ctrl_r[15:8] <= wData_r[15:8];
          end
        end else if (isStat(awAddr_r)) begin
          // Read-only status: writes are accepted and dropped
          s_axi_bresp <= `PSL_RESP_OKAY;
        end else begin
          s_axi_bresp <= `PSL_RESP_SLVERR;
        end
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `PSL_RESP_OKAY;
    end else begin
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        if (isCtrl(s_axi_araddr)) begin
          s_axi_rdata <= {16'h0000, ctrl_r};
          s_axi_rresp <= `PSL_RESP_OKAY;
        end else if (isStat(s_axi_araddr)) begin
          s_axi_rdata <= {16'h0000, statusWord};
          s_axi_rresp <= `PSL_RESP_OKAY;
        end else begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `PSL_RESP_SLVERR;
        end
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end else begin
        s_axi_arready <= ~s_axi_rvalid;
      end
    end
  end

endmodule

`default_nettype wire

// >>> bench/psl_led_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Board lamp: counts every change of level it sees
// ----------------------------------------------------------------
module psl_led_model (
  input  wire         mclk,
  input  wire         ledOn,
  output logic [15:0] flips
);
  logic last_r;
  // The lamp has no reset; the bench only uses differences
  initial flips = 16'h0000;
  always @(posedge mclk) begin
    last_r <= ledOn;
    if (ledOn !== last_r)
      flips <= flips + 16'h0001;
  end
endmodule
`default_nettype wire

// >>> bench/psl_status_led_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "psl_defines.vh"
module psl_status_led_props #(
  parameter [`PSL_CNT_W-1:0] HOLD_CYCLES = `PSL_HOLD_CYC
) (
  input  wire                   mclk,
  input  wire                   rst,
  input  wire                   linkUp,
  input  wire                   speedFast,
  input  wire                   txActive,
  input  wire                   rxActive,
  input  wire                   collision,
  input  wire                   phyActive,
  input  wire                   anLinkCheck,
  input  wire                   ledOn,
  input  wire [`PSL_ADDR_W-1:0] s_axi_awaddr,
  input  wire                   s_axi_awvalid,
  input  wire                   s_axi_awready,
  input  wire [31:0]            s_axi_wdata,
  input  wire [3:0]             s_axi_wstrb,
  input  wire                   s_axi_wvalid,
  input  wire                   s_axi_wready,
  input  wire                   s_axi_bvalid,
  input  wire                   s_axi_bready,
  input  wire                   s_axi_arvalid,
  input  wire                   s_axi_arready,
  input  wire [31:0]            s_axi_rdata,
  input  wire                   s_axi_rvalid,
  input  wire                   s_axi_rready
);
  // ----------------------------------------------------------------
  // Shadow of the control register
  // ----------------------------------------------------------------
  logic [15:0] ctrlSh_r;
  logic        wBusy_r;
  logic [23:0] downCnt_r;
  wire         awHs = s_axi_awvalid && s_axi_awready;
  wire         wHs = s_axi_wvalid && s_axi_wready;
  wire         chkSt = phyActive && anLinkCheck;
  // Shadow may lead the register while a write is open: judge only idle
  wire         nf = !wBusy_r && !ctrlSh_r[15];
  wire         fr = !wBusy_r && ctrlSh_r[15];
  wire         free = nf && !chkSt;
  always @(posedge mclk) begin
    if (rst) begin
      ctrlSh_r <= `PSL_CTRL_RESET;
      wBusy_r <= 1'b0;
      downCnt_r <= 24'h000000;
    end else begin
      if (awHs && wHs && s_axi_awaddr == `PSL_CTRL_OFFSET) begin
        if (s_axi_wstrb[0])
          ctrlSh_r[7:0] <= s_axi_wdata[7:0];
        if (s_axi_wstrb[1])
          ctrlSh_r[15:8] <= s_axi_wdata[15:8];
      end
      if (awHs)
        wBusy_r <= 1'b1;
      else if (s_axi_bvalid && s_axi_bready)
        wBusy_r <= 1'b0;
      if (linkUp)
        downCnt_r <= 24'h000000;
      else if (~&downCnt_r)
        downCnt_r <= downCnt_r + 24'h000001;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  chk_force_on: assert property (
    fr && ctrlSh_r[14:13] == `PSL_FORCE_ON |=> ledOn)
    else $error("forced on LED is dark");
  chk_force_off: assert property (
    fr && ctrlSh_r[14:13] == `PSL_FORCE_OFF |=> !ledOn)
    else $error("forced off LED is lit");
  chk_check_level: assert property (
    nf && chkSt |-> ##1 ledOn == $past(ctrlSh_r[0]))
    else $error("link check level wrong");
  chk_slow_steady: assert property (
    free && linkUp && !speedFast && ctrlSh_r[4] && !txActive
    && !rxActive && !(collision && ctrlSh_r[3]) && !ctrlSh_r[1]
    |=> ledOn) else $error("slow link LED dark");
  chk_nolink_off: assert property (
    free && !linkUp && downCnt_r > HOLD_CYCLES + 24'd2 |=> !ledOn)
    else $error("LED lit with link down");
  chk_hold_lit: assert property (
    $fell(txActive) && free && linkUp && ctrlSh_r[7]
    && ctrlSh_r[9:8] == 2'h0 && ctrlSh_r[3:1] == 3'h0
    |-> ##1 ledOn [*8]) else $error("activity hold too short");
  chk_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  chk_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_write_answer: assert property (
    awHs && wHs |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  cover property (fr ##1 ledOn);
  cover property (nf && chkSt);
  cover property ($fell(txActive) && ctrlSh_r[7]);
endmodule
bind psl_status_led psl_status_led_props #(.HOLD_CYCLES(HOLD_CYCLES)) u_props (
  .mclk(mclk), .rst(rst), .linkUp(linkUp), .speedFast(speedFast),
  .txActive(txActive), .rxActive(rxActive), .collision(collision),
  .phyActive(phyActive), .anLinkCheck(anLinkCheck), .ledOn(ledOn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

// >>> bench/phy_status_led_driver_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "psl_defines.vh"
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin \
  errors++; $display("wrong value %s exp %h got %h", nm, ex, gt); end end
module phy_status_led_driver_test;
  localparam logic [15:0] SC [10] = '{16'h0010, 16'h0010, 16'h0020,
    16'h0020, 16'h0800, 16'h0800, 16'h0400, 16'h0400, 16'h0011, 16'h0010};
  localparam logic [7:0] SS [10] = '{8'h80, 8'hc0, 8'hc0, 8'h80, 8'ha0,
    8'h80, 8'h80, 8'h00, 8'h83, 8'h83};
  localparam logic [15:0] BC [7] = '{16'h0008, 16'h0004, 16'h0002,
    16'h3200, 16'h2200, 16'h0210, 16'h0110};
  localparam logic [7:0] BS [7] = '{8'h84, 8'hc0, 8'h80, 8'h90, 8'h90,
    8'h90, 8'h88};
  localparam int BL [7] = '{4, 4, 4, 13, 0, 13, 13};
  localparam int BH [7] = '{8, 8, 8, 19, 0, 19, 19};
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  sts = 8'h00;
  logic [15:0] awaddr = 16'h0000;
  logic [15:0] araddr = 16'h0000;
  logic [31:0] wdata = 32'h00000000;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  wire         awready, wready, bvalid, arready, rvalid, ledOn;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [15:0] flips;
  int          errors = 0;
  int          total_checks = 0;
  initial forever #20 mclk = ~mclk;
  psl_status_led #(.HOLD_CYCLES(24'd20), .BLINK1_HALF(24'd8),
    .BLINK2_HALF(24'd3)) u_dut (
    .mclk(mclk), .rst(rst), .linkUp(sts[7]), .speedFast(sts[6]),
    .fullDuplex(sts[5]), .txActive(sts[4]), .rxActive(sts[3]),
    .collision(sts[2]), .phyActive(sts[1]), .anLinkCheck(sts[0]),
    .ledOn(ledOn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  psl_led_model u_lamp (.mclk(mclk), .ledOn(ledOn), .flips(flips));
  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge mclk);
      if (!ad && awready === 1'b1) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready === 1'b1) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge mclk);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge mclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic setc(input logic [15:0] v);
    logic [1:0] r;
    wr(`PSL_CTRL_OFFSET, {16'h0000, v}, r);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    rd(`PSL_CTRL_OFFSET, d, r);
    `CHK("ctrl reset", 32'h00000311, d)
    wr(`PSL_CTRL_OFFSET, 32'hffff5aa5, r);
    `CHK("ctrl wr resp", `PSL_RESP_OKAY, r)
    wr(16'h4100, 32'h00000001, r);
    `CHK("unmapped wr resp", `PSL_RESP_SLVERR, r)
    wr(`PSL_STAT_OFFSET, 32'h0000ffff, r);
    `CHK("status wr resp", `PSL_RESP_OKAY, r)
    rd(16'h4100, d, r);
    `CHK("unmapped rd resp", `PSL_RESP_SLVERR, r)
    rd(`PSL_CTRL_OFFSET, d, r);
    `CHK("ctrl readback", 32'h00005aa5, d)
  endtask
  task automatic t_force;
    logic [15:0] f0;
    for (int c = 0; c < 4; c++) begin
      sts <= 8'h80;
      setc({1'b1, c[1:0], 13'h0010});
      f0 = flips;
      cyc(48);
      if (c < 2)
        `CHK("forced level", c[0], ledOn)
      `CHK("force flips", 1'b1, (flips - f0) inside {[4:8]} && c == 2 ||
        (flips - f0) inside {[13:19]} && c == 3 || c < 2 && flips - f0 < 2)
    end
  endtask
  task automatic t_steady;
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 10; i++) begin
      sts <= SS[i];
      setc(SC[i]);
      cyc(3);
      `CHK("steady level", ~i[0], ledOn)
      if (i == 0) begin
        rd(`PSL_STAT_OFFSET, d, r);
        `CHK("status word", 32'h00000119, d)
      end
    end
  endtask
  task automatic t_hold;
    for (int k = 0; k < 2; k++) begin
      sts <= 8'h80;
      setc(k ? 16'h0040 : 16'h0080);
      sts <= k ? 8'h88 : 8'h90;
      cyc(1);
      sts <= 8'h80;
      cyc(12);
      `CHK("hold lit", 1'b1, ledOn)
      cyc(24);
      `CHK("hold over", 1'b0, ledOn)
    end
  endtask
  task automatic t_blink;
    logic [15:0] f0;
    for (int i = 0; i < 7; i++) begin
      sts <= BS[i] & 8'he0;
      setc(BC[i]);
      cyc(4);
      f0 = flips;
      sts <= BS[i];
      cyc(48);
      `CHK("blink flips", 1'b1, (flips - f0) inside {[BL[i]:BH[i]]})
    end
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    cyc(2);
    t_regs;
    t_force;
    t_steady;
    t_hold;
    t_blink;
    report_and_stop;
  end
  // A hung handshake would otherwise stall the run forever
  initial begin
    repeat (5000) @(posedge mclk);
    errors++;
    report_and_stop;
  end
endmodule
`default_nettype wire
